// ### shared/asramc_defs.svh
/*
 * Timing and width constants for the asynchronous SRAM host controller.
 * Assumes a 100 MHz controller clock (10 ns period).
 */
`ifndef ASRAMC_DEFS_SVH
`define ASRAMC_DEFS_SVH

`define ASRAMC_CLK_PERIOD_NS   10
`define ASRAMC_ADDR_WIDTH      18
`define ASRAMC_DATA_WIDTH      16
`define ASRAMC_LANES           2
`define ASRAMC_LANE_WIDTH      8

// least times, in ns as printed
`define ASRAMC_T_SETUP_DATA_NS  5
`define ASRAMC_T_SETUP_ADDR_NS  7
`define ASRAMC_T_BYTE_EN_NS     7
`define ASRAMC_T_PULSE_WE_NS    7
`define ASRAMC_T_OFF_WE_NS      5
`define ASRAMC_T_CYCLE_NS       10
`define ASRAMC_T_DATA_BE_NS     4.5
`define ASRAMC_T_READ_ADDR_NS   10
`define ASRAMC_T_BYTE_OFF_NS    6

// least times round up to whole cycles, never below one
`define ASRAMC_CEIL_CYC(t) \
    ((((t) + `ASRAMC_CLK_PERIOD_NS - 1) / `ASRAMC_CLK_PERIOD_NS) < 1 ? 1 : \
     (((t) + `ASRAMC_CLK_PERIOD_NS - 1) / `ASRAMC_CLK_PERIOD_NS))

// write strobe overlap covers address setup, byte setup and setup+turn-off
`define ASRAMC_WRITE_CYC \
    `ASRAMC_CEIL_CYC(`ASRAMC_T_SETUP_DATA_NS + `ASRAMC_T_OFF_WE_NS)
// read waits for the slower of address access and byte-lane access
`define ASRAMC_READ_CYC   `ASRAMC_CEIL_CYC(`ASRAMC_T_READ_ADDR_NS)
// bus turnaround after a read, covering byte disable to high impedance
`define ASRAMC_TURN_CYC   `ASRAMC_CEIL_CYC(`ASRAMC_T_BYTE_OFF_NS)
`define ASRAMC_COUNT_WIDTH 3

`endif

// ### shared/asramc_pkg.sv
/*
 * Types for the asynchronous SRAM host controller.
 * Assumes asramc_defs.svh is compiled alongside.
 */
package asramc_pkg;

    // gray codes along idle -> setup -> strobe -> hold
    typedef enum logic [2:0] {
        ASRAMC_IDLE   = 3'h0,
        ASRAMC_SETUP  = 3'h1,
        ASRAMC_STROBE = 3'h3,
        ASRAMC_HOLD   = 3'h2,
        ASRAMC_READ   = 3'h6,
        ASRAMC_TURN   = 3'h7
    } asramc_state_type;

endpackage

// ### design/asramc_ctrl.sv
/*
 * Host controller for an asynchronous 256K x 16 SRAM with byte lanes.
 * Assumes the memory pins are wired directly; the bidirectional data bus
 * is resolved outside from dataOut, dataOutEnable_n and dataIn.
 */
`timescale 1ns/1ns
`include "asramc_defs.svh"

// Summary of operation
// - write happens only while strobe, select and a lane enable are low.
// - data timing is referenced to whichever strobe ends the write.
// - write data is valid at least 5 ns before write end.
// - write data holds at least 0 ns past write end.
// - address is stable at least 7 ns before write end.
// - address holds unchanged at least 0 ns past write end.
// - address is valid at least 0 ns before strobes overlap.
// - for select-ended writes, address is valid by select falling.
// - the chosen lane enable is low at least 7 ns before write end.
// - with output enable low, strobe lasts data setup plus turn-off.
// - the write strobe stays high throughout every read.
// - host never drives data while the memory drives it.
// - read needs select, output enable low, strobe high; lanes independent.
module asramc_ctrl (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic                          reqValid,
    input  wire logic                          reqWrite,
    input  wire logic [`ASRAMC_ADDR_WIDTH-1:0] reqAddr,
    input  wire logic [`ASRAMC_DATA_WIDTH-1:0] reqWriteData,
    input  wire logic [`ASRAMC_LANES-1:0]      reqLaneEnable,
    output logic                               reqReady,
    output logic                               readValid,
    output logic [`ASRAMC_DATA_WIDTH-1:0]      readData,
    output logic [`ASRAMC_ADDR_WIDTH-1:0]      memAddr,
    output logic                               chipSelect_n,
    output logic                               outputEnable_n,
    output logic                               writeStrobe_n,
    output logic                               lower_byte_enable_n,
    output logic                               upper_byte_enable_n,
    output logic [`ASRAMC_DATA_WIDTH-1:0]      dataOut,
    output logic [`ASRAMC_DATA_WIDTH-1:0]      dataOutEnable_n,
    input  wire logic [`ASRAMC_DATA_WIDTH-1:0] dataIn
);

    localparam logic [`ASRAMC_COUNT_WIDTH-1:0] WRITE_CYC =
        `ASRAMC_COUNT_WIDTH'(`ASRAMC_WRITE_CYC);
    localparam logic [`ASRAMC_COUNT_WIDTH-1:0] READ_CYC =
        `ASRAMC_COUNT_WIDTH'(`ASRAMC_READ_CYC);
    localparam logic [`ASRAMC_COUNT_WIDTH-1:0] TURN_CYC =
        `ASRAMC_COUNT_WIDTH'(`ASRAMC_TURN_CYC);

    asramc_pkg::asramc_state_type state;
    asramc_pkg::asramc_state_type next_state;
    logic [`ASRAMC_COUNT_WIDTH-1:0] count;
    logic [`ASRAMC_COUNT_WIDTH-1:0] next_count;
    logic                           isWrite;
    logic [`ASRAMC_LANES-1:0]       laneEnable;
    logic                           readPend;
    wire  [`ASRAMC_DATA_WIDTH-1:0]  next_dataOutEnable_n;

    // dataIn is a pin; two flops before anything reads it
    logic [`ASRAMC_DATA_WIDTH-1:0]  dataSync1;
    logic [`ASRAMC_DATA_WIDTH-1:0]  dataSync2;

    wire countDone = (count == '0);
    // a request with no lane enabled would never write; it is refused;
    // reqReady gates the take so nothing lands while an answer is due
    wire reqTake   = (state == asramc_pkg::ASRAMC_IDLE) && reqReady &&
                     reqValid && (reqLaneEnable != '0);
    // the taken request reaches isWrite and laneEnable one edge late,
    // so the bus drive decision looks through to the request itself
    wire curWrite  = reqTake ? reqWrite : isWrite;
    wire [`ASRAMC_LANES-1:0] curLanes =
                     reqTake ? reqLaneEnable : laneEnable;
    wire readEnd   = (state == asramc_pkg::ASRAMC_TURN) && countDone;
    wire inStrobe  = (next_state == asramc_pkg::ASRAMC_STROBE);
    wire inRead    = (next_state == asramc_pkg::ASRAMC_READ);
    wire writeBus  = curWrite && (next_state == asramc_pkg::ASRAMC_SETUP ||
                     next_state == asramc_pkg::ASRAMC_STROBE ||
                     next_state == asramc_pkg::ASRAMC_HOLD);
    wire readLast  = (state == asramc_pkg::ASRAMC_READ) && countDone;
    wire selected  = (next_state != asramc_pkg::ASRAMC_IDLE) &&
                     (next_state != asramc_pkg::ASRAMC_TURN);

    always_comb begin
        next_state = state;
        next_count = countDone ? '0 : count - 1'b1;
        case (state)
            asramc_pkg::ASRAMC_IDLE: begin
                if (reqTake) begin
                    // address settles a full cycle before any strobe
                    next_state = asramc_pkg::ASRAMC_SETUP;
                end
            end
            asramc_pkg::ASRAMC_SETUP: begin
                if (isWrite) begin
                    next_state = asramc_pkg::ASRAMC_STROBE;
                    next_count = WRITE_CYC - 1'b1;
                end else begin
                    next_state = asramc_pkg::ASRAMC_READ;
                    next_count = READ_CYC - 1'b1;
                end
            end
            asramc_pkg::ASRAMC_STROBE: begin
                if (countDone) begin
                    next_state = asramc_pkg::ASRAMC_HOLD;
                end
            end
            asramc_pkg::ASRAMC_HOLD: begin
                next_state = asramc_pkg::ASRAMC_IDLE;
            end
            asramc_pkg::ASRAMC_READ: begin
                if (countDone) begin
                    next_state = asramc_pkg::ASRAMC_TURN;
                    next_count = TURN_CYC - 1'b1;
                end
            end
            asramc_pkg::ASRAMC_TURN: begin
                if (countDone) begin
                    next_state = asramc_pkg::ASRAMC_IDLE;
                end
            end
            default: begin
                next_state = asramc_pkg::ASRAMC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state      <= asramc_pkg::ASRAMC_IDLE;
            count      <= '0;
            isWrite    <= 1'b0;
            laneEnable <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
            if (reqTake) begin
                isWrite    <= reqWrite;
                laneEnable <= reqLaneEnable;
            end
        end
    end

    // address and data change only in idle, so hold after write end is kept
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            memAddr <= '0;
            dataOut <= '0;
        end else if (reqTake) begin
            memAddr <= reqAddr;
            dataOut <= reqWriteData;
        end
    end

    // lane enables fall with the strobe and rise with it; select stays low from setup through hold,
    // so the strobe edge alone ends every write
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            chipSelect_n        <= 1'b1;
            writeStrobe_n       <= 1'b1;
            outputEnable_n      <= 1'b1;
            lower_byte_enable_n <= 1'b1;
            upper_byte_enable_n <= 1'b1;
        end else begin
            chipSelect_n   <= !selected;
            writeStrobe_n  <= !inStrobe;
            outputEnable_n <= !inRead;
            lower_byte_enable_n <= !((inStrobe || inRead) &&
                                     laneEnable[0]);
            upper_byte_enable_n <= !((inStrobe || inRead) &&
                                     laneEnable[1]);
        end
    end

    genvar lane;
    generate
        for (lane = 0; lane < `ASRAMC_LANES; lane++) begin : g_lane
            // drive a lane only in a write, and only if it is enabled
            assign next_dataOutEnable_n[lane*`ASRAMC_LANE_WIDTH +:
                                        `ASRAMC_LANE_WIDTH] =
                {`ASRAMC_LANE_WIDTH{!(writeBus &&
                                      curLanes[lane])}};
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dataOutEnable_n <= '1;
        end else begin
            dataOutEnable_n <= next_dataOutEnable_n;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dataSync1 <= '0;
            dataSync2 <= '0;
            readData  <= '0;
            readValid <= 1'b0;
            readPend  <= 1'b0;
            reqReady  <= 1'b0;
        end else begin
            dataSync1 <= dataIn;
            dataSync2 <= dataSync1;
            // the last sample inside the read window reaches dataSync2
            // one edge after the window closes; capture it on the edge after that
            readPend  <= readEnd;
            readValid <= readPend;
            if (readPend) begin
                readData <= dataSync2;
            end
            // ready waits for the read answer so the next take follows it
            reqReady <= (next_state == asramc_pkg::ASRAMC_IDLE) &&
                        !readLast && !readEnd;
        end
    end

endmodule

// ### sim/asramc_ctrl_chk.sv
/* checker for the sram host controller pins.
   assumes the controller walk of one access at a time. */
`timescale 1ns/1ns
`include "asramc_defs.svh"
module asramc_ctrl_chk (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        reqReady,
    input wire logic        readValid,
    input wire logic [17:0] memAddr,
    input wire logic        chipSelect_n,
    input wire logic        outputEnable_n,
    input wire logic        writeStrobe_n,
    input wire logic        lower_byte_enable_n,
    input wire logic        upper_byte_enable_n,
    input wire logic [15:0] dataOut,
    input wire logic [15:0] dataOutEnable_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire noLane = lower_byte_enable_n && upper_byte_enable_n;
    property p_we_read; !outputEnable_n |-> writeStrobe_n; endproperty
    a_we_read: assert property (p_we_read)
        else $error("strobe low during read");
    property p_no_clash; !outputEnable_n |-> &dataOutEnable_n; endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("host drives bus during read");
    property p_wr_sel; !writeStrobe_n |-> !chipSelect_n && !noLane;
    endproperty
    a_wr_sel: assert property (p_wr_sel)
        else $error("write strobe without select or lane");
    property p_hold;
        $rose(writeStrobe_n) |-> $stable(memAddr) && $stable(dataOut)
            && $stable(dataOutEnable_n) && !chipSelect_n;
    endproperty
    a_hold: assert property (p_hold)
        else $error("address or data moved at write end");
    property p_setup;
        $fell(writeStrobe_n) |-> $stable(memAddr) && $stable(dataOut)
            && !$past(chipSelect_n) ##1 $stable(memAddr) && $stable(dataOut);
    endproperty
    a_setup: assert property (p_setup)
        else $error("address or data not set up before write");
    property p_lane;
        $fell(writeStrobe_n) |-> !noLane ##1 writeStrobe_n || !noLane;
    endproperty
    a_lane: assert property (p_lane)
        else $error("lane enable short against write");
    property p_rd_valid; $rose(outputEnable_n) |-> ##2 readValid;
    endproperty
    a_rd_valid: assert property (p_rd_valid)
        else $error("read result not two cycles after read end");
    property p_busy; !chipSelect_n |-> !reqReady; endproperty
    a_busy: assert property (p_busy)
        else $error("ready while an access is open");
    c_write: cover property ($fell(writeStrobe_n));
    c_read: cover property (readValid);
    c_lower: cover property (!outputEnable_n && upper_byte_enable_n);
endmodule
bind asramc_ctrl asramc_ctrl_chk chk_u (.clk, .reset_n, .reqReady,
    .readValid, .memAddr, .chipSelect_n, .outputEnable_n, .writeStrobe_n,
    .lower_byte_enable_n, .upper_byte_enable_n, .dataOut,
    .dataOutEnable_n);

// ### sim/asramc_sram_model.sv
/* behavioural 256k x 16 sram with byte lanes.
   assumes dataIn is the resolved bus level. */
`timescale 1ns/1ns
module asramc_sram_model (
    input wire logic [17:0] memAddr,
    input wire logic        chipSelect_n,
    input wire logic        outputEnable_n,
    input wire logic        writeStrobe_n,
    input wire logic        lower_byte_enable_n,
    input wire logic        upper_byte_enable_n,
    input wire logic [15:0] dataIn,
    output logic [15:0]     memData,
    output logic [15:0]     memDrive
);
    logic [15:0] mem [0:262143];
    logic [17:0] pa;
    logic [15:0] pd;
    logic [1:0]  pl;
    wire lo = !lower_byte_enable_n;
    wire hi = !upper_byte_enable_n;
    wire wrOn = !chipSelect_n && !writeStrobe_n && (lo || hi);
    // deselect powers down and floats everything
    wire rdOn = !chipSelect_n && !outputEnable_n && writeStrobe_n;
    always @* if (wrOn) begin
        pa = memAddr;
        pd = dataIn;
        pl = {hi, lo};
    end
    // first strobe to rise ends the write
    always @(negedge wrOn) begin
        if (pl[0]) mem[pa][7:0] = pd[7:0];
        if (pl[1]) mem[pa][15:8] = pd[15:8];
    end
    // late enough after select/strobe, well inside access and release
    assign #3 memDrive = {{8{rdOn && hi}}, {8{rdOn && lo}}};
    assign memData = mem[memAddr];
endmodule

// ### sim/async_sram_byte_write_read_timing_bench.sv
/* self-checking bench for the sram host controller.
   assumes the sram model and the bound checker. */
`timescale 1ns/1ns
module async_sram_byte_write_read_timing_bench;
    logic clk = 0, reset_n = 0, reqValid = 0, reqWrite = 0;
    logic [17:0] reqAddr = 0;
    logic [15:0] reqWriteData = 0, q;
    logic [1:0]  reqLaneEnable = 0;
    wire reqReady, readValid, chipSelect_n, outputEnable_n, writeStrobe_n;
    wire lower_byte_enable_n, upper_byte_enable_n;
    wire [17:0] memAddr;
    wire [15:0] readData, dataOut, dataOutEnable_n, memData, memDrive;
    // floating bus shows the inverse so stale values never pass
    wire [15:0] dataIn = (~dataOutEnable_n & dataOut)
        | (dataOutEnable_n & memDrive & memData)
        | (dataOutEnable_n & ~memDrive & ~dataOut);
    int failures = 0, n_checks = 0;
    asramc_ctrl dut_u (.clk, .reset_n, .reqValid, .reqWrite, .reqAddr,
        .reqWriteData, .reqLaneEnable, .reqReady, .readValid, .readData,
        .memAddr, .chipSelect_n, .outputEnable_n, .writeStrobe_n,
        .lower_byte_enable_n, .upper_byte_enable_n, .dataOut,
        .dataOutEnable_n, .dataIn);
    asramc_sram_model mem_u (.memAddr, .chipSelect_n, .outputEnable_n,
        .writeStrobe_n, .lower_byte_enable_n, .upper_byte_enable_n,
        .dataIn, .memData, .memDrive);
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [17:0] a,
                       input logic [15:0] d, input logic [1:0] l);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 50) begin
            @(posedge clk); #1; n++;
        end
        {reqValid, reqWrite, reqAddr, reqWriteData} = {1'b1, w, a, d};
        reqLaneEnable = l;
        @(posedge clk); #1;
        reqValid = 0;
        q = 'x;
        while (!w && readValid !== 1'b1 && n < 50) begin
            @(posedge clk); #1; n++;
        end
        if (!w) q = readData;
        if (n >= 50) failures++;
    endtask
    task automatic t_reset;
        chk(dataOutEnable_n, 16'hffff);
        chk({9'h0, chipSelect_n, outputEnable_n, writeStrobe_n,
             lower_byte_enable_n, upper_byte_enable_n, reqReady,
             readValid}, 16'h007c);
    endtask
    task automatic t_word;
        acc(1, 18'h3ffff, 16'ha5c3, 2'h3);
        acc(1, 18'h00000, 16'h5a3c, 2'h3);
        acc(0, 18'h3ffff, 16'h0, 2'h3);
        chk(q, 16'ha5c3);
        acc(0, 18'h00000, 16'h0, 2'h3);
        chk(q, 16'h5a3c);
    endtask
    task automatic t_bytes;
        acc(1, 18'h00005, 16'h1234, 2'h3);
        acc(1, 18'h00005, 16'hab77, 2'h2);
        acc(1, 18'h00005, 16'h88cd, 2'h1);
        acc(0, 18'h00005, 16'h0, 2'h3);
        chk(q, 16'habcd);
        acc(0, 18'h00005, 16'h0, 2'h1);
        chk({8'h0, q[7:0]}, 16'h00cd);
        acc(0, 18'h00005, 16'h0, 2'h2);
        chk({8'h0, q[15:8]}, 16'h00ab);
    endtask
    task automatic t_refuse;
        acc(1, 18'h00005, 16'hffff, 2'h0);
        chk({15'h0, reqReady}, 16'h0001);
        acc(0, 18'h00005, 16'h0, 2'h3);
        chk(q, 16'habcd);
    endtask
    initial begin
        #20000;
        failures++;
        test_done;
    end
    initial begin
        repeat (2) @(posedge clk);
        #1;
        t_reset;
        reset_n = 1;
        t_word;
        t_bytes;
        t_refuse;
        test_done;
    end
endmodule
